// ===== design/asc_cfg.svh
// Named offsets, bit positions, widths and reset values of the acquisition status/control pair.
// Assumes it is included by bare name from every design file that needs the constants.
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

`define ASC_AW              5
`define ASC_DW              16
`define ASC_OFF_STATUS      5'h00
`define ASC_OFF_CMD1        5'h00
`define ASC_OFF_CTRL2       5'h02
`define ASC_RDATA_IDLE      16'h0000

`define ASC_CTRL2_W         10
`define ASC_CTRL2_RST       10'h000
`define ASC_CMD1_RST        4'h0

`define ASC_C2_PORT1_DRV    9
`define ASC_C2_PORT0_DRV    8
`define ASC_C2_MASTER_IE    7
`define ASC_C2_CNT2_IE      6
`define ASC_C2_DAC_SEL      5
`define ASC_C2_SCAN_MODE    4
`define ASC_C2_P4_RCV       3
`define ASC_C2_P4_XMT       2
`define ASC_C2_P2_RCV       1
`define ASC_C2_P2_XMT       0

`define ASC_C1_STOP_IE      9
`define ASC_C1_TC_IE        8
`define ASC_C1_CONV_IE      7
`define ASC_C1_DUAL_DMA     6
`define ASC_E_STOP          3
`define ASC_E_TC            2
`define ASC_E_CONV          1
`define ASC_E_DUAL          0

`define ASC_SYNC_N          5
`define ASC_S_CNT2          0
`define ASC_S_CNT5          1
`define ASC_S_DMATC         2
`define ASC_S_P4IN          3
`define ASC_S_P2IN          4
`define ASC_SYNC_RST        5'h00

`endif

// ===== design/asc_pin_sync.sv
// Three-stage synchronisers with settled level and edge pulses for pin inputs.
// Assumes one clock; a change counts once the second and third stages agree.
`timescale 1ns/1ns
`include "asc_cfg.svh"
module asc_pin_sync (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [`ASC_SYNC_N-1:0]  pin_in,
  output logic      [`ASC_SYNC_N-1:0]  level,
  output logic      [`ASC_SYNC_N-1:0]  rise,
  output logic      [`ASC_SYNC_N-1:0]  fall
);
  logic [`ASC_SYNC_N-1:0] s1_r;
  logic [`ASC_SYNC_N-1:0] s2_r;
  logic [`ASC_SYNC_N-1:0] s3_r;

  genvar g;
  generate
    for (g = 0; g < `ASC_SYNC_N; g = g + 1) begin : g_bit
      // The first stage feeds only the second, so metastability never reaches a gate.
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1_r[g]  <= 1'b0;
          s2_r[g]  <= 1'b0;
          s3_r[g]  <= 1'b0;
          level[g] <= 1'b0;
          rise[g]  <= 1'b0;
          fall[g]  <= 1'b0;
        end else begin
          s1_r[g] <= pin_in[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          // The level only moves when the two later stages agree.
          if (s2_r[g] == s3_r[g]) begin
            level[g] <= s3_r[g];
          end
          rise[g] <= (s2_r[g] == s3_r[g]) && s3_r[g] && !level[g];
          fall[g] <= (s2_r[g] == s3_r[g]) && !s3_r[g] && level[g];
        end
      end
    end
  endgenerate

  // A rise and a fall can never be reported together.
  edge_excl_a: assert property (@(posedge clk) disable iff (!rst_n) !(|(rise & fall)))
    else $error("Rise and fall pulse at once.");
endmodule : asc_pin_sync

// ===== design/asc_pkg.sv
// Types shared by the acquisition status/control block.
// Assumes the constants of asc_cfg.svh; holds no logic.
package asc_pkg;
  typedef enum logic [0:0] {
    ASC_ACQ_IDLE = 1'b0,
    ASC_ACQ_RUN  = 1'b1
  } asc_acq_state_t;
endpackage : asc_pkg

// ===== design/asc_regs.sv
// Status word and second control word of the sampling section, with the interrupt logic.
// Assumes the host bus decode delivers word/byte transfers on clk, strobes as one-cycle
// pulses from the same clock, and sampling-section signals already on this clock.
`timescale 1ns/1ns
`include "asc_cfg.svh"
module asc_regs (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [`ASC_AW-1:0]   bus_addr,
  input  wire logic                 bus_word,
  input  wire logic                 bus_rd,
  input  wire logic                 bus_wr,
  input  wire logic [`ASC_DW-1:0]   bus_wdata,
  output logic      [`ASC_DW-1:0]   bus_rdata,
  output logic                      bus_rvalid,
  input  wire logic                 acq_clear_strobe,
  input  wire logic                 cnt2_irq_clear_strobe,
  input  wire logic                 dma_tc_clear_strobe,
  input  wire logic                 acq_start,
  input  wire logic                 acq_done,
  input  wire logic                 conv_start,
  input  wire logic                 conv_busy,
  input  wire logic                 conv_done,
  input  wire logic                 fifo_not_empty,
  input  wire logic                 fifo_full,
  input  wire logic                 dma_xfer_done,
  input  wire logic [1:0]           amp_gain_sel,
  input  wire logic [2:0]           chan_addr_low,
  input  wire logic                 chan_upper_sel,
  input  wire logic                 diff_mode,
  input  wire logic                 dac_write,
  input  wire logic                 counter_output_two,
  input  wire logic                 counter_output_five,
  input  wire logic                 dma_tc_pin,
  input  wire logic                 port_four_in,
  input  wire logic                 port_two_in,
  output logic                      port_four_out,
  output logic                      port_four_oe,
  output logic                      port_two_out,
  output logic                      port_two_oe,
  output logic                      stop_trigger_line,
  output logic                      stop_trigger_oe,
  output logic                      counter_one_gate,
  output logic                      counter_one_gate_oe,
  output logic                      port_zero_drive_on,
  output logic                      port_one_drive_on,
  output logic                      scan_interval_mode,
  output logic                      dac_load,
  output logic                      acq_abort,
  output logic                      acq_running,
  output logic                      irq
);
  logic [`ASC_CTRL2_W-1:0]   ctrl2_r;
  logic [3:0]                en_r;
  logic                      acq_stop_irq_r;
  logic                      cnt2_edge_irq_r;
  logic                      dma_tc_irq_r;
  logic                      overflow_r;
  logic                      overrun_r;
  logic                      dma_chan_sel_r;
  asc_pkg::asc_acq_state_t   acq_state_r;
  logic [`ASC_DW-1:0]        status_word;
  logic [`ASC_SYNC_N-1:0]    pin_level;
  logic [`ASC_SYNC_N-1:0]    pin_rise;
  logic [`ASC_SYNC_N-1:0]    pin_fall;
  logic                      wr_ctrl2;
  logic                      wr_cmd1;
  logic                      rd_status;
  logic                      ovf_evt;
  logic                      ovr_evt;
  logic                      stop_evt;
  logic                      irq_nxt;

  // Byte transfers at these offsets belong to another register group and are left alone.
  function automatic logic word_hit(input logic [`ASC_AW-1:0] a, input logic w,
                                    input logic [`ASC_AW-1:0] off);
    word_hit = w && (a == off);
  endfunction : word_hit

  assign wr_ctrl2  = bus_wr && word_hit(bus_addr, bus_word, `ASC_OFF_CTRL2);
  assign wr_cmd1   = bus_wr && word_hit(bus_addr, bus_word, `ASC_OFF_CMD1);
  assign rd_status = bus_rd && word_hit(bus_addr, bus_word, `ASC_OFF_STATUS);

  // Pins from outside the clock domain all pass the three-stage synchroniser.
  asc_pin_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in ({port_two_in, port_four_in, dma_tc_pin, counter_output_five, counter_output_two}),
    .level  (pin_level),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  // Second control word; only bits 9-0 exist, so 15-10 are simply dropped.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl2_r <= `ASC_CTRL2_RST;
    end else if (wr_ctrl2) begin
      ctrl2_r <= bus_wdata[`ASC_CTRL2_W-1:0];
    end
  end

  // Enable bits of the first command word that this block consumes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_r <= `ASC_CMD1_RST;
    end else if (wr_cmd1) begin
      en_r <= {bus_wdata[`ASC_C1_STOP_IE], bus_wdata[`ASC_C1_TC_IE],
               bus_wdata[`ASC_C1_CONV_IE], bus_wdata[`ASC_C1_DUAL_DMA]};
    end
  end

  // Error events; either one ends a running acquisition at once.
  assign ovf_evt  = conv_done && fifo_full;
  assign ovr_evt  = conv_start && conv_busy;
  assign stop_evt = (acq_state_r == asc_pkg::ASC_ACQ_RUN) && (acq_done || ovf_evt || ovr_evt);

  // Acquisition progress; the clear strobe cancels a run without raising the stop flag.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acq_state_r <= asc_pkg::ASC_ACQ_IDLE;
    end else begin
      case (acq_state_r)
        asc_pkg::ASC_ACQ_IDLE: begin
          if (acq_start && !acq_clear_strobe) begin
            acq_state_r <= asc_pkg::ASC_ACQ_RUN;
          end
        end
        asc_pkg::ASC_ACQ_RUN: begin
          if (stop_evt || acq_clear_strobe) begin
            acq_state_r <= asc_pkg::ASC_ACQ_IDLE;
          end
        end
        default: begin
          acq_state_r <= asc_pkg::ASC_ACQ_IDLE;
        end
      endcase
    end
  end

  // Sticky flags: an event in the clearing cycle wins, so nothing is lost.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acq_stop_irq_r  <= 1'b0;
      overflow_r      <= 1'b0;
      overrun_r       <= 1'b0;
    end else begin
      acq_stop_irq_r <= stop_evt || (acq_stop_irq_r && !acq_clear_strobe);
      overflow_r     <= ovf_evt || (overflow_r && !acq_clear_strobe);
      overrun_r      <= ovr_evt || (overrun_r && !acq_clear_strobe);
    end
  end

  // Counter-two edge and DMA terminal-count flags; the acquisition clear also drops TC.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt2_edge_irq_r <= 1'b0;
      dma_tc_irq_r    <= 1'b0;
    end else begin
      cnt2_edge_irq_r <= pin_rise[`ASC_S_CNT2] ||
                         (cnt2_edge_irq_r && !cnt2_irq_clear_strobe);
      dma_tc_irq_r    <= pin_rise[`ASC_S_DMATC] ||
                         (dma_tc_irq_r && !dma_tc_clear_strobe && !acq_clear_strobe);
    end
  end

  // Channel in use; single mode pins it to the first channel.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dma_chan_sel_r <= 1'b0;
    end else if (!en_r[`ASC_E_DUAL] || acq_clear_strobe) begin
      dma_chan_sel_r <= 1'b0;
    end else if (dma_xfer_done) begin
      dma_chan_sel_r <= !dma_chan_sel_r;
    end
  end

  // Request combines the master gate with each source and its own enable.
  assign irq_nxt = ctrl2_r[`ASC_C2_MASTER_IE] &&
                   ((acq_stop_irq_r && en_r[`ASC_E_STOP]) ||
                    (dma_tc_irq_r && en_r[`ASC_E_TC]) ||
                    (fifo_not_empty && en_r[`ASC_E_CONV]) ||
                    (cnt2_edge_irq_r && ctrl2_r[`ASC_C2_CNT2_IE]));

  // Registered request so the pin never glitches with flag updates.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

  // Status assembly; bank enables follow single-ended or differential selection.
  assign status_word = {irq,
                        acq_stop_irq_r,
                        fifo_not_empty,
                        cnt2_edge_irq_r,
                        acq_state_r == asc_pkg::ASC_ACQ_RUN,
                        dma_tc_irq_r,
                        overflow_r,
                        overrun_r,
                        amp_gain_sel,
                        dma_chan_sel_r,
                        diff_mode || chan_upper_sel,
                        diff_mode || !chan_upper_sel,
                        chan_addr_low};

  // Read data is registered and returns zero for anything but a status word read.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_rdata  <= `ASC_RDATA_IDLE;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rdata  <= rd_status ? status_word : `ASC_RDATA_IDLE;
      bus_rvalid <= bus_rd;
    end
  end

  // DAC update: immediate on a write, or on the falling edge of counter output two.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dac_load  <= 1'b0;
      acq_abort <= 1'b0;
    end else begin
      dac_load  <= ctrl2_r[`ASC_C2_DAC_SEL] ? pin_fall[`ASC_S_CNT2] : dac_write;
      // An error stop aborts even when the normal end falls in the same cycle.
      acq_abort <= stop_evt && (ovf_evt || ovr_evt);
    end
  end

  // Trigger-bus switch routing; data comes from the synchronised, registered levels.
  assign port_four_out       = pin_level[`ASC_S_CNT5];
  assign port_four_oe        = ctrl2_r[`ASC_C2_P4_XMT];
  assign port_two_out        = pin_level[`ASC_S_CNT2];
  assign port_two_oe         = ctrl2_r[`ASC_C2_P2_XMT];
  assign stop_trigger_line   = pin_level[`ASC_S_P4IN];
  assign stop_trigger_oe     = ctrl2_r[`ASC_C2_P4_RCV];
  assign counter_one_gate    = pin_level[`ASC_S_P2IN];
  assign counter_one_gate_oe = ctrl2_r[`ASC_C2_P2_RCV];
  assign port_zero_drive_on  = ctrl2_r[`ASC_C2_PORT0_DRV];
  assign port_one_drive_on   = ctrl2_r[`ASC_C2_PORT1_DRV];
  assign scan_interval_mode  = ctrl2_r[`ASC_C2_SCAN_MODE];
  assign acq_running         = acq_state_r == asc_pkg::ASC_ACQ_RUN;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ctrl_write_low_a: assert property (
    wr_ctrl2 |=> ctrl2_r == $past(bus_wdata[`ASC_CTRL2_W-1:0]))
    else $error("Control word did not take bits 9-0.");
  irq_master_gate_a: assert property (!ctrl2_r[`ASC_C2_MASTER_IE] |=> !irq)
    else $error("Interrupt raised with master enable off.");
  status_irq_mirror_a: assert property (rd_status |=> bus_rdata[15] == $past(irq))
    else $error("Status bit 15 differs from request.");
  sample_ready_read_a: assert property (
    rd_status |=> bus_rdata[13] == $past(fifo_not_empty))
    else $error("Status bit 13 differs from FIFO state.");
  cnt2_flag_set_a: assert property (pin_rise[`ASC_S_CNT2] |=> cnt2_edge_irq_r)
    else $error("Counter-two flag missed an edge.");
  // The stop flag is checked in the cycle after the overflow, since a clear may follow right after.
  overflow_stop_a: assert property (acq_running && ovf_evt |=> overflow_r && !acq_running
                                    && acq_stop_irq_r)
    else $error("Overflow did not stop acquisition.");
  overrun_stop_a: assert property (acq_running && ovr_evt |=> overrun_r && acq_abort)
    else $error("Overrun did not stop acquisition.");
  stop_flag_clear_a: assert property (acq_clear_strobe && !stop_evt |=> !acq_stop_irq_r)
    else $error("Stop flag survived the clear.");
  single_dma_chan_a: assert property (!en_r[`ASC_E_DUAL] |=> !dma_chan_sel_r)
    else $error("Second DMA channel used in single mode.");
  dac_immediate_a: assert property (!ctrl2_r[`ASC_C2_DAC_SEL] && dac_write |=> dac_load)
    else $error("Immediate DAC update missing.");
  reset_ctrl_zero_a: assert property (
    $rose(rst_n) |-> ctrl2_r == `ASC_CTRL2_RST && !irq)
    else $error("Control word not zero after reset.");

  acq_done_cov: cover property (acq_running && acq_done ##1 acq_stop_irq_r);
  acq_error_cov: cover property (acq_running && ovf_evt);
  irq_cnt2_cov: cover property (cnt2_edge_irq_r && ctrl2_r[`ASC_C2_CNT2_IE] ##1 irq);
  dma_swap_cov: cover property (en_r[`ASC_E_DUAL] && dma_xfer_done ##1 dma_chan_sel_r);
endmodule : asc_regs

// ===== verif/asc_host_model.sv
// Host bus partner: word and byte reads and writes toward the status/control pair.
// Assumes the block's clock; requests change just after a rising edge, held to that edge.
`timescale 1ns/1ns
`include "asc_cfg.svh"
module asc_host_model (
  input  wire logic               clk,
  output logic      [`ASC_AW-1:0] bus_addr,
  output logic                    bus_word,
  output logic                    bus_rd,
  output logic                    bus_wr,
  output logic      [`ASC_DW-1:0] bus_wdata,
  input  wire logic [`ASC_DW-1:0] bus_rdata,
  input  wire logic               bus_rvalid
);
  // Idle lines carry the inverse of their last value, so a stale request never looks valid.
  initial begin
    bus_addr  = 5'h1F;
    bus_word  = 1'b0;
    bus_rd    = 1'b0;
    bus_wr    = 1'b0;
    bus_wdata = 16'hFFFF;
  end

  // One write, held through the edge that takes it.
  task automatic wr(input logic [`ASC_AW-1:0] a, input logic [`ASC_DW-1:0] d, input logic w);
    @(posedge clk);
    bus_addr  <= a;
    bus_word  <= w;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
    bus_addr  <= ~a;
    bus_word  <= ~w;
    bus_wdata <= ~d;
  endtask : wr

  // One read; the data stays unknown if no answer comes within three edges.
  task automatic rd(input logic [`ASC_AW-1:0] a, input logic w, output logic [`ASC_DW-1:0] d);
    d = 'x;
    @(posedge clk);
    bus_addr <= a;
    bus_word <= w;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    bus_word <= ~w;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      if (bus_rvalid === 1'b1) begin
        d = bus_rdata;
        break;
      end
    end
  endtask : rd
endmodule : asc_host_model

// ===== verif/tb_acq_status_and_control_regs.sv
// Self-checking bench for the status word and second control word.
// Assumes the host model above and a behavioural model of flags kept here in integers.
`timescale 1ns/1ns
`include "asc_cfg.svh"
module tb_acq_status_and_control_regs;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [`ASC_AW-1:0] bus_addr;
  logic               bus_word, bus_rd, bus_wr, bus_rvalid;
  logic [`ASC_DW-1:0] bus_wdata, bus_rdata, v;
  logic [8:0]         pv = 9'h000;
  logic [4:0]         pins = 5'h00;
  logic               conv_busy = 1'b0, fifo_full = 1'b0, fifo_not_empty = 1'b0;
  logic               chan_upper_sel = 1'b0, diff_mode = 1'b0;
  logic [1:0]         amp_gain_sel = 2'h0;
  logic [2:0]         chan_addr_low = 3'h0;
  logic [14:0]        o;
  int bad_count = 0, cmp_count = 0, cycles = 0, abort_n = 0, load_n = 0, n, r;
  int m_stop = 0, m_ovf = 0, m_ovr = 0, m_c2 = 0, m_tc = 0, m_run = 0, m_ch = 0;
  int m_ctl = 0, m_cmd1 = 0;

  always #5 clk = ~clk;

  asc_host_model host (.clk(clk), .bus_addr(bus_addr), .bus_word(bus_word), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));

  asc_regs uut (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_word(bus_word),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .acq_clear_strobe(pv[0]), .cnt2_irq_clear_strobe(pv[1]),
    .dma_tc_clear_strobe(pv[2]), .acq_start(pv[3]), .acq_done(pv[4]), .conv_start(pv[5]),
    .conv_busy(conv_busy), .conv_done(pv[6]), .fifo_not_empty(fifo_not_empty),
    .fifo_full(fifo_full), .dma_xfer_done(pv[7]), .amp_gain_sel(amp_gain_sel),
    .chan_addr_low(chan_addr_low), .chan_upper_sel(chan_upper_sel), .diff_mode(diff_mode),
    .dac_write(pv[8]), .counter_output_two(pins[0]), .counter_output_five(pins[1]),
    .dma_tc_pin(pins[2]), .port_four_in(pins[3]), .port_two_in(pins[4]),
    .port_zero_drive_on(o[0]), .port_one_drive_on(o[1]), .scan_interval_mode(o[2]),
    .stop_trigger_oe(o[3]), .port_four_oe(o[4]), .counter_one_gate_oe(o[5]),
    .port_two_oe(o[6]), .stop_trigger_line(o[7]), .port_four_out(o[8]),
    .counter_one_gate(o[9]), .port_two_out(o[10]), .acq_running(o[11]), .irq(o[12]),
    .dac_load(o[13]), .acq_abort(o[14]));

  // Pulse counters and the hang limit; the run takes a few hundred cycles at most.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (o[14] === 1'b1) abort_n++;
    if (o[13] === 1'b1) load_n++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  function automatic logic exp_irq();
    return m_ctl[7] & ((m_stop[0] & m_cmd1[9]) | (m_tc[0] & m_cmd1[8]) |
                       (fifo_not_empty & m_cmd1[7]) | (m_c2[0] & m_ctl[6]));
  endfunction : exp_irq

  function automatic logic [15:0] exp_status();
    return {exp_irq(), m_stop[0], fifo_not_empty, m_c2[0], m_run[0], m_tc[0], m_ovf[0],
            m_ovr[0], amp_gain_sel, m_ch[0], diff_mode | chan_upper_sel,
            diff_mode | ~chan_upper_sel, chan_addr_low};
  endfunction : exp_status

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Status read plus every output except dac_load and acq_abort against the model.
  task automatic chk_all();
    host.rd(5'h00, 1'b1, v);
    check(v, exp_status(), "status");
    check({5'h00, o[10:0]}, {5'h00, pins[0], pins[4], pins[1], pins[3], m_ctl[0], m_ctl[1],
          m_ctl[2], m_ctl[3], m_ctl[4], m_ctl[9], m_ctl[8]}, "control outputs");
    check({14'h0, o[12:11]}, {14'h0, exp_irq(), m_run[0]}, "irq and running");
  endtask : chk_all

  task automatic wctl(input int d);
    host.wr(5'h02, d[15:0], 1'b1);
    m_ctl = d & 32'h3FF;
  endtask : wctl

  task automatic wcmd1(input int d);
    host.wr(5'h00, d[15:0], 1'b1);
    m_cmd1 = d;
  endtask : wcmd1

  task automatic pulse(input int i);
    @(posedge clk);
    pv[i] <= 1'b1;
    @(posedge clk);
    pv[i] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  // Pins pass a three-stage synchroniser, so each change gets eight cycles to settle.
  task automatic pin(input int k, input logic b);
    @(posedge clk);
    pins[k] <= b;
    repeat (8) @(posedge clk);
  endtask : pin

  task automatic lv(input logic [15:0] x);
    @(posedge clk);
    {amp_gain_sel, chan_addr_low, chan_upper_sel, diff_mode, fifo_not_empty} <= x[7:0];
    pins <= x[12:8] & 5'h1A;
    repeat (8) @(posedge clk);
  endtask : lv

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    void'($urandom(32'hB3C7B4FA));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk_all();
    $display("test reset done");
    // Junk in bits 15-10, byte writes and a stray address must all leave no trace.
    for (int k = 0; k < 8; k++) begin
      r = $urandom;
      wctl(r);
      host.wr(5'h02, ~r[15:0], 1'b0);
      host.wr(5'h06, ~r[15:0], 1'b1);
      lv(16'($urandom));
      chk_all();
      host.rd(5'h02, 1'b1, v);
      check(v, 16'h0000, "control read");
      host.rd(5'h00, 1'b0, v);
      check(v, 16'h0000, "byte read");
    end
    $display("test control done");
    wcmd1(16'h0380);
    wctl(16'h0080);
    lv(16'h0000);
    pulse(3);
    m_run = 1;
    chk_all();
    pulse(4);
    m_run = 0;
    m_stop = 1;
    chk_all();
    check(16'(abort_n), 16'h0000, "abort on normal stop");
    wctl(16'h0000);
    chk_all();
    wctl(16'h0080);
    pulse(0);
    m_stop = 0;
    lv(16'h0001);
    chk_all();
    wcmd1(16'h0000);
    chk_all();
    $display("test acquisition done");
    // Overflow first, then overrun, each in mid-acquisition.
    for (int k = 0; k < 2; k++) begin
      pulse(3);
      @(posedge clk);
      fifo_full <= (k == 0);
      conv_busy <= (k == 1);
      pulse(k == 0 ? 6 : 5);
      m_ovf = (k == 0);
      m_ovr = (k == 1);
      m_stop = 1;
      chk_all();
      check(16'(abort_n), 16'(k + 1), "abort count");
      @(posedge clk);
      fifo_full <= 1'b0;
      conv_busy <= 1'b0;
      pulse(0);
      m_ovf = 0;
      m_ovr = 0;
      m_stop = 0;
      chk_all();
    end
    $display("test errors done");
    for (int k = 0; k < 2; k++) begin
      wctl(k == 0 ? 16'h00C0 : 16'h0080);
      pin(0, 1'b1);
      m_c2 = 1;
      chk_all();
      pulse(1);
      m_c2 = 0;
      pin(0, 1'b0);
      chk_all();
    end
    $display("test counter two done");
    wcmd1(16'h0140);
    pin(2, 1'b1);
    m_tc = 1;
    chk_all();
    pulse(2);
    m_tc = 0;
    pin(2, 1'b0);
    for (int k = 0; k < 3; k++) begin
      pulse(7);
      m_ch = 1 - m_ch;
      chk_all();
    end
    pulse(0);
    m_ch = 0;
    wcmd1(16'h0100);
    pulse(7);
    chk_all();
    $display("test dma done");
    wctl(16'h0000);
    n = load_n;
    pulse(8);
    check(16'(load_n - n), 16'h0001, "dac immediate");
    wctl(16'h0020);
    pulse(8);
    pin(0, 1'b1);
    check(16'(load_n - n), 16'h0001, "dac held");
    pin(0, 1'b0);
    check(16'(load_n - n), 16'h0002, "dac on counter");
    m_c2 = 1;
    chk_all();
    pulse(1);
    m_c2 = 0;
    chk_all();
    $display("test dac done");
    // A second reset in mid-run must drop every control bit and enable again.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    m_ctl = 0;
    m_cmd1 = 0;
    repeat (4) @(posedge clk);
    chk_all();
    $display("test second reset done");
    final_report();
  end
endmodule : tb_acq_status_and_control_regs
